// ---- hw/vic_edge_flags.sv ----
// Edge detectors and sticky request flags of the six request lines.
`timescale 1ns/10ps
module vic_edge_flags #(
    parameter int LINES = 6
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    vic_req_if.detect req
);
    import vic_pkg::*;

    logic [LINES-1:0] prev_q;
    logic arm_q;
    logic [LINES-1:0] flag_q;
    logic [LINES-1:0] hit;

    // Lines in the rising set detect a rising edge, the others a falling edge.
    for (genvar g = 0; g < LINES; g++) begin : g_det
        assign hit[g] = arm_q & (RISE_EDGE_LINES[g] ? (req.level[g] & ~prev_q[g]) : (~req.level[g] & prev_q[g]));
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            prev_q <= '0;
            arm_q <= 1'b0;
            flag_q <= FLAGS_RESET;
        end else begin
            prev_q <= req.level;
            arm_q <= 1'b1;
            flag_q <= hit | (flag_q & ~req.clear);
        end
    end

    assign req.flags = flag_q;
    assign req.events = hit;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    property p_fall_zero;
        arm_q && $fell(req.level[0]) |=> flag_q[0];
    endproperty
    a_fall_zero: assert property (p_fall_zero) else $error("Falling edge on line zero not recorded.");
    property p_rise_three;
        arm_q && $rose(req.level[3]) |=> flag_q[3] && !hit[3];
    endproperty
    a_rise_three: assert property (p_rise_three) else $error("Rising edge on line three not recorded.");
    property p_no_spurious;
        $rose(flag_q[2]) |-> $past(hit[2]);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("Line two flag set without an edge.");
    property p_set_beats_clear;
        hit[1] && req.clear[1] |=> flag_q[1];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("Edge lost against a clear.");
endmodule : vic_edge_flags

// ---- hw/vic_pkg.sv ----
// Package with constants, register indices and types of the vectored interrupt controller.
package vic_pkg;
    localparam int NUM_LINES = 6;
    localparam int LINE_W = 3;
    localparam logic [5:0] RISE_EDGE_LINES = 6'h38;
    localparam int AXI_AW = 12;
    localparam int AXI_DW = 32;
    localparam int PMEM_AW = 12;
    localparam logic [7:0] IDX_PRIO = 8'hf9;
    localparam logic [7:0] IDX_REQ = 8'hfa;
    localparam logic [7:0] IDX_MASK = 8'hfb;
    localparam logic [7:0] IDX_CFG = 8'hf0;
    localparam logic [7:0] IDX_ISTAT = 8'he0;
    localparam logic [7:0] IDX_ICLR = 8'he1;
    localparam logic [7:0] IDX_IEN = 8'he2;
    localparam logic [7:0] IDX_SAVED = 8'he3;
    localparam int MASK_GLOBAL_BIT = 7;
    localparam int CFG_ANALOG_BIT = 0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam int GRANT_TO_BRANCH = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH_HI, ST_FETCH_LO, ST_FINISH} vic_state_e;

    // True when a byte address selects the word of the given register index.
    function automatic logic reg_hit(input logic [AXI_AW-1:0] addr, input logic [7:0] idx);
        return addr == {2'h0, idx, 2'h0};
    endfunction : reg_hit
endpackage : vic_pkg

// ---- hw/vic_prio_enc.sv ----
// Programmable rotating priority encoder over the enabled request lines.
`timescale 1ns/10ps
module vic_prio_enc #(
    parameter int LINES = 6
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    vic_req_if.encode enc
);
    import vic_pkg::*;

    logic [3:0] pick_w;

    // The selected line is highest; priority falls cyclically from it.
    function automatic logic [3:0] pick(input logic [5:0] en, input logic [2:0] top);
        int idx;
        int start;
        logic [3:0] r;
        r = 4'h0;
        start = (int'(top) >= LINES) ? 0 : int'(top);
        for (int k = LINES - 1; k >= 0; k--) begin
            idx = (start + k) % LINES;
            if (en[idx]) begin
                r = {1'b1, idx[2:0]};
            end
        end
        return r;
    endfunction : pick

    assign pick_w = pick(enc.enabled, enc.prio);
    assign enc.win_valid = pick_w[3];
    assign enc.win_line = pick_w[2:0];

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    property p_top_wins;
        (int'(enc.prio) < LINES) && enc.enabled[enc.prio] |-> enc.win_valid && enc.win_line == enc.prio;
    endproperty
    a_top_wins: assert property (p_top_wins) else $error("Selected top line did not win.");
    property p_win_enabled;
        enc.win_valid |-> enc.enabled[enc.win_line] && enc.enabled != 6'h00;
    endproperty
    a_win_enabled: assert property (p_win_enabled) else $error("Winner is not an enabled line.");
endmodule : vic_prio_enc

// ---- hw/vic_req_if.sv ----
// Interface joining the controller core to its edge detector and priority encoder.
`timescale 1ns/10ps
interface vic_req_if;
    logic [5:0] level;
    logic [5:0] clear;
    logic [5:0] flags;
    logic [5:0] events;
    logic [5:0] enabled;
    logic [2:0] prio;
    logic win_valid;
    logic [2:0] win_line;
    modport detect (input level, clear, output flags, events);
    modport encode (input enabled, prio, output win_valid, win_line);
    modport ctrl (output level, clear, enabled, prio, input flags, events, win_valid, win_line);
endinterface : vic_req_if

// ---- hw/vic_top.sv ----
// Top of the vectored interrupt controller with its AXI4-Lite register slave.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module vic_top (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [vic_pkg::AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [vic_pkg::AXI_DW-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [vic_pkg::AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [vic_pkg::AXI_DW-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic input_pin_one_in,
    input wire logic input_pin_two_in,
    input wire logic input_pin_three_in,
    input wire logic comparator_out_a_in,
    input wire logic comparator_out_b_in,
    input wire logic timer_zero_count_end_in,
    input wire logic timer_zero_prescale_end_in,
    input wire logic timer_one_count_end_in,
    input wire logic timer_one_prescale_end_in,
    input wire logic core_int_ack_in,
    input wire logic [15:0] core_pc_in,
    input wire logic [7:0] core_flags_in,
    input wire logic [7:0] pmem_data_in,
    output logic core_int_req_out,
    output logic [vic_pkg::PMEM_AW-1:0] pmem_addr_out,
    output logic pmem_rd_out,
    output logic save_out,
    output logic [15:0] saved_pc_out,
    output logic [7:0] saved_flags_out,
    output logic branch_out,
    output logic [15:0] handler_addr_out,
    output logic irq_out
);
    import vic_pkg::*;

    vic_req_if req ();

    vic_state_e state_q;
    logic [7:0] mask_q;
    logic [7:0] prio_q;
    logic [7:0] cfg_q;
    logic [5:0] istat_q;
    logic [5:0] ien_q;
    logic [2:0] line_q;
    logic [7:0] vec_hi_q;
    logic int_req_q;
    logic [PMEM_AW-1:0] pmem_addr_q;
    logic pmem_rd_q;
    logic save_q;
    logic [15:0] saved_pc_q;
    logic [7:0] saved_flags_q;
    logic branch_q;
    logic [15:0] handler_q;
    logic irq_q;
    logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane_q;
    logic [1:0] bresp_q, rresp_q;
    logic [AXI_DW-1:0] rdata_q;

    wire logic analog = cfg_q[CFG_ANALOG_BIT];
    wire logic take = (state_q == ST_IDLE) && int_req_q && core_int_ack_in && req.win_valid;
    wire logic [5:0] grant_clr = take ? (6'h01 << req.win_line) : 6'h00;
    wire logic aw_take = s_axi_awvalid_in && awready_q;
    wire logic w_take = s_axi_wvalid_in && wready_q;
    wire logic do_write = aw_got_q && w_got_q;
    wire logic aw_got_d = do_write ? 1'b0 : (aw_got_q || aw_take);
    wire logic w_got_d = do_write ? 1'b0 : (w_got_q || w_take);
    wire logic bvalid_d = do_write || (bvalid_q && !s_axi_bready_in);
    wire logic ar_take = s_axi_arvalid_in && arready_q;
    wire logic rvalid_d = ar_take || (rvalid_q && !s_axi_rready_in);
    wire logic wr_en = do_write && wlane_q;
    wire logic wr_prio = wr_en && reg_hit(awaddr_q, IDX_PRIO);
    wire logic wr_mask = wr_en && reg_hit(awaddr_q, IDX_MASK);
    wire logic wr_cfg = wr_en && reg_hit(awaddr_q, IDX_CFG);
    wire logic wr_iclr = wr_en && reg_hit(awaddr_q, IDX_ICLR);
    wire logic wr_ien = wr_en && reg_hit(awaddr_q, IDX_IEN);
    wire logic w_mapped = reg_hit(awaddr_q, IDX_PRIO) || reg_hit(awaddr_q, IDX_MASK) || reg_hit(awaddr_q, IDX_CFG)
        || reg_hit(awaddr_q, IDX_ICLR) || reg_hit(awaddr_q, IDX_IEN) || reg_hit(awaddr_q, IDX_REQ)
        || reg_hit(awaddr_q, IDX_ISTAT) || reg_hit(awaddr_q, IDX_SAVED);
    wire logic r_mapped = reg_hit(s_axi_araddr_in, IDX_PRIO) || reg_hit(s_axi_araddr_in, IDX_MASK)
        || reg_hit(s_axi_araddr_in, IDX_CFG) || reg_hit(s_axi_araddr_in, IDX_ICLR)
        || reg_hit(s_axi_araddr_in, IDX_IEN) || reg_hit(s_axi_araddr_in, IDX_REQ)
        || reg_hit(s_axi_araddr_in, IDX_ISTAT) || reg_hit(s_axi_araddr_in, IDX_SAVED);
    wire logic [AXI_DW-1:0] rd_word =
        reg_hit(s_axi_araddr_in, IDX_REQ) ? {26'h0, req.flags} :
        reg_hit(s_axi_araddr_in, IDX_MASK) ? {24'h0, mask_q} :
        reg_hit(s_axi_araddr_in, IDX_CFG) ? {24'h0, cfg_q} :
        reg_hit(s_axi_araddr_in, IDX_ISTAT) ? {26'h0, istat_q} :
        reg_hit(s_axi_araddr_in, IDX_IEN) ? {26'h0, ien_q} :
        reg_hit(s_axi_araddr_in, IDX_SAVED) ? {8'h0, saved_flags_q, saved_pc_q} : 32'h0;
    wire logic [5:0] istat_d = req.events | (istat_q & ~(wr_iclr ? wdata_q[5:0] : 6'h00));

    // Line sources; in analog mode the reference pin feeds the comparators and raises nothing.
    assign req.level[0] = analog ? comparator_out_b_in : input_pin_two_in;
    assign req.level[1] = analog ? 1'b1 : input_pin_three_in;
    assign req.level[2] = analog ? comparator_out_a_in : input_pin_one_in;
    assign req.level[3] = analog ? comparator_out_b_in : input_pin_two_in;
    assign req.level[4] = timer_zero_count_end_in & timer_zero_prescale_end_in;
    assign req.level[5] = timer_one_count_end_in & timer_one_prescale_end_in;
    assign req.clear = grant_clr;
    assign req.enabled = req.flags & mask_q[5:0] & {6{mask_q[MASK_GLOBAL_BIT]}};
    assign req.prio = prio_q[2:0];

    vic_edge_flags #(.LINES(NUM_LINES)) vic_edge_flags_inst (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .req(req.detect)
    );

    vic_prio_enc #(.LINES(NUM_LINES)) vic_prio_enc_inst (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .enc(req.encode)
    );

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            mask_q <= MASK_RESET;
            prio_q <= PRIO_RESET;
            cfg_q <= CFG_RESET;
            ien_q <= 6'h00;
            istat_q <= 6'h00;
            irq_q <= 1'b0;
        end else begin
            if (take) begin
                mask_q <= {1'b0, (wr_mask ? wdata_q[6:0] : mask_q[6:0])};
            end else if (wr_mask) begin
                mask_q <= wdata_q;
            end
            if (wr_prio) begin
                prio_q <= wdata_q;
            end
            if (wr_cfg) begin
                cfg_q <= wdata_q;
            end
            if (wr_ien) begin
                ien_q <= wdata_q[5:0];
            end
            istat_q <= istat_d;
            irq_q <= |(istat_d & ien_q);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
            int_req_q <= 1'b0;
            line_q <= 3'h0;
            vec_hi_q <= 8'h00;
            pmem_addr_q <= '0;
            pmem_rd_q <= 1'b0;
            save_q <= 1'b0;
            saved_pc_q <= 16'h0000;
            saved_flags_q <= 8'h00;
            branch_q <= 1'b0;
            handler_q <= 16'h0000;
        end else begin
            save_q <= take;
            branch_q <= 1'b0;
            int_req_q <= (state_q == ST_IDLE) && !take && req.win_valid;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        line_q <= req.win_line;
                        saved_pc_q <= core_pc_in;
                        saved_flags_q <= core_flags_in;
                        pmem_addr_q <= {8'h00, req.win_line, 1'b0};
                        pmem_rd_q <= 1'b1;
                        state_q <= ST_FETCH_HI;
                    end
                end
                ST_FETCH_HI: begin
                    pmem_addr_q <= {8'h00, line_q, 1'b1};
                    state_q <= ST_FETCH_LO;
                end
                ST_FETCH_LO: begin
                    vec_hi_q <= pmem_data_in;
                    pmem_rd_q <= 1'b0;
                    state_q <= ST_FINISH;
                end
                ST_FINISH: begin
                    handler_q <= {vec_hi_q, pmem_data_in};
                    branch_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= !aw_got_d && !bvalid_d;
            wready_q <= !w_got_d && !bvalid_d;
            bvalid_q <= bvalid_d;
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr_in;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata_in[7:0];
                wlane_q <= s_axi_wstrb_in[0];
            end
            if (do_write) begin
                bresp_q <= w_mapped ? RESP_OKAY : RESP_DECERR;
            end
            if (ar_take) begin
                rdata_q <= rd_word;
                rresp_q <= r_mapped ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rdata_out = rdata_q;
    assign core_int_req_out = int_req_q;
    assign pmem_addr_out = pmem_addr_q;
    assign pmem_rd_out = pmem_rd_q;
    assign save_out = save_q;
    assign saved_pc_out = saved_pc_q;
    assign saved_flags_out = saved_flags_q;
    assign branch_out = branch_q;
    assign handler_addr_out = handler_q;
    assign irq_out = irq_q;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    property p_grant_disables;
        take |=> !mask_q[MASK_GLOBAL_BIT] && !int_req_q;
    endproperty
    a_grant_disables: assert property (p_grant_disables) else $error("Grant left interrupts enabled.");
    property p_save_state;
        take |=> save_q && saved_pc_q == $past(core_pc_in) && saved_flags_q == $past(core_flags_in);
    endproperty
    a_save_state: assert property (p_save_state) else $error("Program counter or flags not saved.");
    property p_vector_addr;
        take |=> pmem_rd_q && pmem_addr_q == {8'h00, $past(req.win_line), 1'b0} ##1 pmem_addr_q[0];
    endproperty
    a_vector_addr: assert property (p_vector_addr) else $error("Wrong vector byte address.");
    property p_branch_time;
        take |-> ##GRANT_TO_BRANCH branch_q && handler_q == {$past(pmem_data_in, 2), $past(pmem_data_in)};
    endproperty
    a_branch_time: assert property (p_branch_time) else $error("Handler address wrong or late.");
    property p_req_gated;
        int_req_q |-> $past(mask_q[MASK_GLOBAL_BIT]) && $past(req.enabled) != 6'h00;
    endproperty
    a_req_gated: assert property (p_req_gated) else $error("Request raised while masked.");
    property p_prio_write;
        wr_prio |=> prio_q == $past(wdata_q);
    endproperty
    a_prio_write: assert property (p_prio_write) else $error("Priority write not stored.");
    property p_grant_flag;
        take && !req.events[req.win_line] |=> !req.flags[$past(req.win_line)];
    endproperty
    a_grant_flag: assert property (p_grant_flag) else $error("Granted flag not cleared.");
endmodule : vic_top

// ---- verif/vic_core_model.sv ----
// Behavioural core sequencer and vector memory answering the interrupt cycle.
`timescale 1ns/10ps
module vic_core_model (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic int_req_in,
    input wire logic pmem_rd_in,
    input wire logic [11:0] pmem_addr_in,
    output logic int_ack_out,
    output logic [7:0] pmem_data_out
);
    logic [1:0] wait_q;
    logic slow_q;
    logic rd_q;
    logic [11:0] addr_q;
    logic [7:0] junk_q;
    // Acknowledges alternate between prompt and slow answers.
    always @(posedge clk_sys_in) begin
        rd_q <= pmem_rd_in;
        addr_q <= pmem_addr_in;
        junk_q <= junk_q + 8'h35;
        int_ack_out <= 1'b0;
        if (!rst_b_in) begin
            wait_q <= 2'h0;
            slow_q <= 1'b0;
            junk_q <= 8'h5a;
        end else if (int_req_in && !int_ack_out) begin
            if (wait_q == 2'h0) begin
                int_ack_out <= 1'b1;
                wait_q <= slow_q ? 2'h0 : 2'h3;
                slow_q <= ~slow_q;
            end else begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
    // Each vector byte is a function of its address; outside reads the bus shows a changing pattern.
    assign pmem_data_out = rd_q ? {addr_q[3:0], ~addr_q[3:0]} : junk_q;
endmodule : vic_core_model

// ---- verif/vic_tb_top.sv ----
// Self-checking testbench of the vectored interrupt controller.
`timescale 1ns/10ps
module vic_tb_top;
    import vic_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [8:0] pins = 9'h01f;
    logic [15:0] pc = 16'h0;
    logic [7:0] flg = 8'h0;
    logic awready, wready, bvalid, arready, rvalid, int_req, ack, pmem_rd, save, branch, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [11:0] paddr;
    logic [7:0] pdata, sflags;
    logic [15:0] spc, handler;
    logic [5:0] rem = 6'h00;
    int line;
    int eb[6] = '{1, 2, 0, 1, 5, 7};
    int errors = 0;
    int check_count = 0;
    int saves = 0;
    int vec_reads = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    // Counts save pulses and vector read cycles so that both strobes are checked.
    always @(posedge clk_sys_in) begin
        if (save === 1'b1) saves <= saves + 1;
        if (pmem_rd === 1'b1) vec_reads <= vec_reads + 1;
    end

    vic_top vic_top_inst (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .input_pin_one_in(pins[0]), .input_pin_two_in(pins[1]), .input_pin_three_in(pins[2]),
        .comparator_out_a_in(pins[3]), .comparator_out_b_in(pins[4]),
        .timer_zero_count_end_in(pins[5]), .timer_zero_prescale_end_in(pins[6]),
        .timer_one_count_end_in(pins[7]), .timer_one_prescale_end_in(pins[8]),
        .core_int_ack_in(ack), .core_pc_in(pc), .core_flags_in(flg), .pmem_data_in(pdata),
        .core_int_req_out(int_req), .pmem_addr_out(paddr), .pmem_rd_out(pmem_rd), .save_out(save),
        .saved_pc_out(spc), .saved_flags_out(sflags), .branch_out(branch),
        .handler_addr_out(handler), .irq_out(irq)
    );

    vic_core_model vic_core_model_inst (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .int_req_in(int_req), .pmem_rd_in(pmem_rd),
        .pmem_addr_in(paddr), .int_ack_out(ack), .pmem_data_out(pdata)
    );

    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : ad

    function automatic logic [15:0] vec(input int l);
        logic [3:0] a;
        a = 4'(2 * l);
        return {a, ~a, a + 4'h1, ~(a + 4'h1)};
    endfunction : vec

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk_sys_in);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk($sformatf("bresp %h", a), bresp, er);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_sys_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk($sformatf("rdata %h", a), rdata, e);
        chk($sformatf("rresp %h", a), rresp, er);
        rready <= 1'b0;
    endtask : rd

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        errors++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(ad(IDX_MASK), MASK_RESET, RESP_OKAY);
        rd(ad(IDX_REQ), {2'h0, FLAGS_RESET}, RESP_OKAY);
        rd(12'h000, 8'h00, RESP_DECERR);
        wr(12'h000, 8'hff, RESP_DECERR);
        wr(ad(IDX_PRIO), 8'h03, RESP_OKAY);
        rd(ad(IDX_PRIO), 8'h00, RESP_OKAY);
        $display("test reset_and_map done");
        for (int i = 0; i < 6; i++) begin
            if (i > 3) begin
                pins[eb[i]] <= 1'b1;
                repeat (3) @(posedge clk_sys_in);
                rd(ad(IDX_REQ), 8'(rem), RESP_OKAY);
                pins[eb[i] + 1] <= 1'b1;
            end else begin
                pins[eb[i]] <= (i == 3);
            end
            repeat (3) @(posedge clk_sys_in);
            rem[i] = 1'b1;
            rd(ad(IDX_REQ), 8'(rem), RESP_OKAY);
            chk("int_req", int_req, 1'b0);
        end
        $display("test edge_sources done");
        for (int k = 0; k < 6; k++) begin
            line = (3 + k) % 6;
            pc <= 16'h4000 + 16'(line);
            flg <= 8'h80 | 8'(line);
            wr(ad(IDX_MASK), 8'hbf, RESP_OKAY);
            while (branch !== 1'b1) @(posedge clk_sys_in);
            chk("handler", handler, vec(line));
            chk("saved_pc", spc, 16'h4000 + 16'(line));
            chk("saved_flags", sflags, 8'h80 | 8'(line));
            rd(ad(IDX_SAVED), {8'h00, 8'h80 | 8'(line), 16'h4000 + 16'(line)}, RESP_OKAY);
            chk("int_req", int_req, 1'b0);
            rd(ad(IDX_MASK), 8'h3f, RESP_OKAY);
            rem[line] = 1'b0;
            rd(ad(IDX_REQ), 8'(rem), RESP_OKAY);
        end
        chk("save_count", saves, 6);
        chk("vector_reads", vec_reads, 12);
        $display("test grants done");
        wr(ad(IDX_CFG), 8'h01, RESP_OKAY);
        wr(ad(IDX_ICLR), 8'h3f, RESP_OKAY);
        for (int j = 0; j < 4; j++) begin
            pins[(j == 0 || j == 3) ? 4 : 3] <= (j > 1);
            repeat (3) @(posedge clk_sys_in);
        end
        rd(ad(IDX_REQ), 8'h0d, RESP_OKAY);
        rd(ad(IDX_ISTAT), 8'h0d, RESP_OKAY);
        chk("irq", irq, 1'b0);
        chk("int_req", int_req, 1'b0);
        wr(ad(IDX_IEN), 8'h01, RESP_OKAY);
        rd(ad(IDX_IEN), 8'h01, RESP_OKAY);
        chk("irq", irq, 1'b1);
        wr(ad(IDX_ICLR), 8'h01, RESP_OKAY);
        rd(ad(IDX_ISTAT), 8'h0c, RESP_OKAY);
        chk("irq", irq, 1'b0);
        $display("test analog_and_irq done");
        conclude();
    end
endmodule : vic_tb_top
